/* File: hw/mshi_pkg.sv */
// shared constants and types of the modem serial host interface
package mshi_pkg;
	// ************************************************************
	// timing
	// ************************************************************
	localparam int CLK_HZ = 25_000_000;
	localparam int PAUSE_MAX_MS = 170;
	localparam int PAUSE_MAX_CYC = (CLK_HZ / 1000) * PAUSE_MAX_MS;
	localparam int RSSI_HOLD_S = 7;
	localparam int RSSI_HOLD_CYC = CLK_HZ * RSSI_HOLD_S;
	localparam logic [3:0] FRAME_BITS = 4'ha;
	// ************************************************************
	// register offsets
	// ************************************************************
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_PAUSE = 8'h04;
	localparam logic [7:0] OFS_BITCYC = 8'h08;
	localparam logic [7:0] OFS_THRESH = 8'h0c;
	localparam logic [7:0] OFS_STATUS = 8'h10;
	localparam logic [7:0] OFS_RSSI = 8'h14;
	localparam logic [7:0] OFS_RESP = 8'h18;
	// ************************************************************
	// fields and reset values
	// ************************************************************
	localparam int CTRL_RECOG_BIT = 0;
	localparam int CTRL_CTS_LSB = 1;
	localparam int CTRL_BAND_LSB = 3;
	localparam int CTRL_ADDR_LSB = 8;
	localparam int STAT_OVF_BIT = 3;
	localparam int STAT_CNT_LSB = 16;
	localparam logic RECOG_RST = 1'b1;
	localparam logic [7:0] PAUSE_MIN = 8'h03;
	localparam logic [7:0] PAUSE_RST = 8'h03;
	localparam logic [15:0] BITCYC_RST = 16'h0a2c;
	localparam logic signed [7:0] THRESH_MIN = -8'sd118;
	localparam logic signed [7:0] THRESH_MAX = -8'sd80;
	localparam logic [7:0] ADDR_RST = 8'h00;
	// ************************************************************
	// characters, buffer, encodings
	// ************************************************************
	localparam logic [7:0] CHR_PLUS = 8'h2b;
	localparam logic [7:0] CHR_MINUS = 8'h2d;
	localparam logic [7:0] PREFIX0 = 8'h53;
	localparam logic [7:0] PREFIX1 = 8'h4c;
	localparam logic [1:0] SEQ_LEN = 2'h3;
	localparam int BUF_DEPTH = 1024;
	localparam logic [10:0] NEAR_FULL = 11'h3c0;
	typedef enum logic [1:0] {MSHI_BAND_UHF, MSHI_BAND_800, MSHI_BAND_900} mshi_band_e;
	typedef enum logic [1:0] {MSHI_CTS_CLEAR, MSHI_CTS_BUF, MSHI_CTS_DUTY} mshi_cts_e;
	typedef enum logic [1:0] {MSHI_RESP_OK, MSHI_RESP_ERROR, MSHI_RESP_VALUE} mshi_resp_e;
	typedef enum logic [1:0] {MSHI_TX_IDLE, MSHI_TX_WAIT, MSHI_TX_SYNC, MSHI_TX_SEND} mshi_tx_e;
endpackage

/* File: hw/mshi_pause_det.sv */
// pause detector on the host transmit-data line
module mshi_pause_det import mshi_pkg::*; #(
	parameter int MAX_CYC = PAUSE_MAX_CYC
) (
	input wire logic core_clk, // module clock
	input wire logic rst_n, // async reset, active low
	input wire logic host_tx_line, // raw host line
	input wire logic [7:0] pause_len, // pause in characters
	input wire logic [15:0] bit_cyc, // clocks per bit
	output logic paused, // line idle for pause time
	output logic pause_pulse // one cycle when pause reached
);
	typedef struct packed {
		logic [2:0] sync;
		logic [22:0] cnt;
		logic paused;
		logic pulse;
	} mshi_pd_s;
	localparam logic [27:0] MAX_LIM = 28'(MAX_CYC);
	mshi_pd_s st_reg, st_next;
	logic [27:0] lim_raw;
	logic [22:0] lim;
	always_comb begin
		// operands widened first so the product cannot wrap at 16 bits
		lim_raw = {20'h00000, pause_len} * {24'h000000, FRAME_BITS} * {12'h000, bit_cyc};
		lim = (lim_raw > MAX_LIM) ? MAX_LIM[22:0] : lim_raw[22:0];
		st_next = st_reg;
		st_next.sync = {st_reg.sync[1:0], host_tx_line};
		st_next.pulse = 1'b0;
		// edge taken from the two settled stages only
		if (st_reg.sync[2] != st_reg.sync[1]) begin
			st_next.cnt = '0;
			st_next.paused = 1'b0;
		end else if (st_reg.cnt < lim) begin
			st_next.cnt = st_reg.cnt + 23'h000001;
		end else if (!st_reg.paused) begin
			st_next.paused = 1'b1;
			st_next.pulse = 1'b1;
		end
	end
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_reg <= '0;
			// idle line level, so release of reset is no false edge
			st_reg.sync <= '1;
		end else begin
			st_reg <= st_next;
		end
	end
	assign paused = st_reg.paused;
	assign pause_pulse = st_reg.pulse;
endmodule // mshi_pause_det

/* File: hw/mshi_tx_buf.sv */
// transmit buffer, flip-flop storage with registered output stage
module mshi_tx_buf import mshi_pkg::*; (
	input wire logic core_clk, // module clock
	input wire logic rst_n, // async reset, active low
	input wire logic flush, // drop all content
	input wire logic in_valid, // write strobe
	input wire logic [7:0] in_data, // write byte
	output logic in_ready, // not full
	input wire logic out_en, // allow loading output stage
	output logic out_valid, // output byte valid
	output logic [7:0] out_data, // output byte
	input wire logic out_ready, // output byte taken
	output logic [10:0] count // bytes held incl. output stage
);
	typedef struct packed {
		logic [BUF_DEPTH-1:0][7:0] mem;
		logic [9:0] wr;
		logic [9:0] rd;
		logic [10:0] used;
		logic ov;
		logic [7:0] od;
		logic full;
		logic [10:0] cnt;
	} mshi_buf_s;
	mshi_buf_s st_reg, st_next;
	logic wr_ok, rd_ok;
	always_comb begin
		st_next = st_reg;
		wr_ok = in_valid && !st_reg.full;
		rd_ok = out_en && (st_reg.used != 11'h000) && (!st_reg.ov || out_ready);
		if (st_reg.ov && out_ready) begin
			st_next.ov = 1'b0;
		end
		if (rd_ok) begin
			st_next.ov = 1'b1;
			st_next.od = st_reg.mem[st_reg.rd];
			st_next.rd = st_reg.rd + 10'h001;
		end
		if (wr_ok) begin
			st_next.mem[st_reg.wr] = in_data;
			st_next.wr = st_reg.wr + 10'h001;
		end
		st_next.used = st_reg.used + {10'h000, wr_ok} - {10'h000, rd_ok};
		if (flush) begin
			st_next.wr = '0;
			st_next.rd = '0;
			st_next.used = '0;
			st_next.ov = 1'b0;
		end
		st_next.full = (st_next.used + {10'h000, st_next.ov}) >= 11'(BUF_DEPTH);
		st_next.cnt = st_next.used + {10'h000, st_next.ov};
	end
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end
	assign in_ready = !st_reg.full;
	assign out_valid = st_reg.ov;
	assign out_data = st_reg.od;
	assign count = st_reg.cnt;
endmodule // mshi_tx_buf

/* File: hw/mshi_top.sv */
// host serial interface top: apb registers, command mode, tx control, cts, rssi
// Behaviour
// - three pluses after pauses enter command mode, OK
// - command mode forces recognition on, radio off
// - three minuses exit, OK, restore setting, radio on
// - exit on hopping band requests device reset
// - stored recognition setting is software writable
// - pause means no host line change long enough
// - empty buffer plus pause stops tx, back receive
// - config command needs pause before first char
// - address start char needs preceding pause
// - pause length 3..255 characters, reset 3
// - pause time is characters times frame time
// - pause time clamped to 170 ms
// - host data starts tx, buffered during sync
// - tx ends only after pause and empty buffer
// - 1 kB buffer, overrun flushes and restarts
// - data during reception waits for free channel
// - clear mode: cts off in rx, end, near full
// - buffer mode: cts off only near full
// - duty mode on 800 band: cts shows window, outside data dropped
// - search only above threshold, -118 disables gate
// - last rssi held 7 s then zero
// - commands answered ok, value or error
module mshi_top import mshi_pkg::*; #(
	parameter int PAUSE_CYC = PAUSE_MAX_CYC, // clamp of pause time
	parameter int RSSI_CYC = RSSI_HOLD_CYC // rssi hold time
) (
	input wire logic core_clk, // 25 MHz clock
	input wire logic rst_n, // async reset, active low
	input wire logic psel, // apb select
	input wire logic penable, // apb enable
	input wire logic pwrite, // apb write
	input wire logic [7:0] paddr, // apb byte address
	input wire logic [31:0] pwdata, // apb write data
	output logic [31:0] prdata, // apb read data
	output logic pready, // apb ready
	output logic pslverr, // apb error on unmapped
	input wire logic host_tx_line, // host transmit-data pin
	input wire logic [7:0] host_byte, // received host byte
	input wire logic host_byte_valid, // host byte strobe
	output logic cts_out, // clear to send, high active
	input wire logic radio_rx_busy, // radio receiving
	input wire logic radio_sync_done, // sync signal sent
	output logic [7:0] radio_tx_data, // byte to radio
	output logic radio_tx_valid, // byte to radio valid
	input wire logic radio_tx_ready, // radio takes byte
	output logic radio_tx_on, // transmitter keyed
	output logic radio_tx_en, // radio tx function enabled
	output logic radio_rx_en, // radio rx function enabled
	output logic search_en, // message search enabled
	input wire logic [7:0] rssi_in, // signed dbm now
	input wire logic rssi_msg_done, // message received pulse
	input wire logic duty_ok, // duty window open
	output logic dev_reset_req, // device reset pulse
	output logic resp_valid, // response strobe
	output logic [1:0] resp_code, // response kind
	output logic cfg_cmd_start, // valid config command start
	output logic addr_start, // address start char seen
	output logic recog_active // command recognition in effect
);
	// ************************************************************
	// state
	// ************************************************************
	typedef struct packed {
		logic recog;
		mshi_cts_e cts_mode;
		mshi_band_e band;
		logic [7:0] addr_chr;
		logic [7:0] pause_len;
		logic [15:0] bit_cyc;
		logic signed [7:0] thresh;
		logic ovf;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic cmd_mode;
		logic [1:0] seq_cnt;
		logic pause_seen;
		logic pfx_wait;
		mshi_tx_e tx;
		logic tx_on;
		logic cts;
		logic search;
		logic [7:0] rssi_hold;
		logic [27:0] rssi_tmr;
		logic rst_req;
		logic resp_v;
		mshi_resp_e resp;
		logic cfg_start;
		logic addr_hit;
		logic recog_eff;
		logic radio_en;
	} mshi_top_s;
	mshi_top_s st_reg, st_next;
	logic paused, pause_pulse;
	logic buf_in_v, buf_in_ready, buf_flush, buf_out_en;
	logic [10:0] buf_count;
	logic wr_acc, rd_setup, byte_ok, data_byte, near_full, ovf_now;
	function automatic logic map_hit(input logic [7:0] a);
		map_hit = (a == OFS_CTRL) || (a == OFS_PAUSE) || (a == OFS_BITCYC) ||
			(a == OFS_THRESH) || (a == OFS_STATUS) || (a == OFS_RSSI) || (a == OFS_RESP);
	endfunction
	function automatic logic signed [7:0] clamp_thr(input logic signed [7:0] v);
		if (v > THRESH_MAX) begin
			clamp_thr = THRESH_MAX;
		end else if (v < THRESH_MIN) begin
			clamp_thr = THRESH_MIN;
		end else begin
			clamp_thr = v;
		end
	endfunction
	// ************************************************************
	// leaves
	// ************************************************************
	mshi_pause_det #(.MAX_CYC(PAUSE_CYC)) u_pause (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.host_tx_line(host_tx_line),
		.pause_len(st_reg.pause_len),
		.bit_cyc(st_reg.bit_cyc),
		.paused(paused),
		.pause_pulse(pause_pulse)
	);
	mshi_tx_buf u_buf (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.flush(buf_flush),
		.in_valid(buf_in_v),
		.in_data(host_byte),
		.in_ready(buf_in_ready),
		.out_en(buf_out_en),
		.out_valid(radio_tx_valid),
		.out_data(radio_tx_data),
		.out_ready(radio_tx_ready),
		.count(buf_count)
	);
	// ************************************************************
	// next state
	// ************************************************************
	always_comb begin
		st_next = st_reg;
		wr_acc = psel && penable && pwrite && st_reg.pready;
		rd_setup = psel && !penable;
		byte_ok = host_byte_valid && st_reg.pause_seen;
		// duty-limited band drops data outside the window
		data_byte = host_byte_valid && !st_reg.cmd_mode &&
			!(st_reg.cts_mode == MSHI_CTS_DUTY && st_reg.band == MSHI_BAND_800 && !duty_ok);
		ovf_now = data_byte && !buf_in_ready;
		buf_in_v = data_byte && buf_in_ready;
		buf_flush = ovf_now;
		buf_out_en = (st_reg.tx == MSHI_TX_SEND);
		near_full = buf_count >= NEAR_FULL;
		st_next.rst_req = 1'b0;
		st_next.resp_v = 1'b0;
		st_next.cfg_start = 1'b0;
		st_next.addr_hit = 1'b0;
		// apb: data is prepared in setup so pready can rise in access
		st_next.pready = rd_setup;
		st_next.pslverr = rd_setup && !map_hit(paddr);
		if (rd_setup) begin
			unique case (paddr)
				OFS_CTRL: st_next.prdata = {16'h0000, st_reg.addr_chr, 3'h0, st_reg.band,
					st_reg.cts_mode, st_reg.recog};
				OFS_PAUSE: st_next.prdata = {24'h000000, st_reg.pause_len};
				OFS_BITCYC: st_next.prdata = {16'h0000, st_reg.bit_cyc};
				OFS_THRESH: st_next.prdata = {24'h000000, st_reg.thresh};
				OFS_STATUS: st_next.prdata = {5'h00, buf_count, 12'h000, st_reg.ovf, paused,
					st_reg.tx_on, st_reg.cmd_mode};
				OFS_RSSI: st_next.prdata = {24'h000000, st_reg.rssi_hold};
				default: st_next.prdata = 32'h00000000;
			endcase
		end
		if (wr_acc) begin
			unique case (paddr)
				OFS_CTRL: begin
					st_next.recog = pwdata[CTRL_RECOG_BIT];
					st_next.cts_mode = mshi_cts_e'(pwdata[CTRL_CTS_LSB +: 2]);
					st_next.band = mshi_band_e'(pwdata[CTRL_BAND_LSB +: 2]);
					st_next.addr_chr = pwdata[CTRL_ADDR_LSB +: 8];
				end
				OFS_PAUSE: st_next.pause_len = (pwdata[7:0] < PAUSE_MIN) ? PAUSE_MIN :
					pwdata[7:0];
				OFS_BITCYC: st_next.bit_cyc = pwdata[15:0];
				OFS_THRESH: st_next.thresh = clamp_thr(pwdata[7:0]);
				OFS_STATUS: if (pwdata[STAT_OVF_BIT]) st_next.ovf = 1'b0;
				OFS_RESP: begin
					st_next.resp_v = 1'b1;
					st_next.resp = mshi_resp_e'(pwdata[1:0]);
				end
				default: st_next.resp_v = 1'b0;
			endcase
		end
		if (ovf_now) begin
			st_next.ovf = 1'b1;
		end
		// ********************************************************
		// pause tracking and sequences
		// ********************************************************
		if (host_byte_valid) begin
			st_next.pause_seen = 1'b0;
			st_next.pfx_wait = 1'b0;
			if (!byte_ok) begin
				st_next.seq_cnt = '0;
			end else if (!st_reg.cmd_mode && host_byte == CHR_PLUS) begin
				st_next.seq_cnt = st_reg.seq_cnt + 2'h1;
			end else if (st_reg.cmd_mode && host_byte == CHR_MINUS) begin
				st_next.seq_cnt = st_reg.seq_cnt + 2'h1;
			end else begin
				st_next.seq_cnt = '0;
			end
			if (st_reg.recog_eff && byte_ok && host_byte == PREFIX0) begin
				st_next.pfx_wait = 1'b1;
			end
			if (st_reg.pfx_wait && host_byte == PREFIX1) begin
				st_next.cfg_start = 1'b1;
			end
			st_next.addr_hit = byte_ok && !st_reg.cmd_mode && host_byte == st_reg.addr_chr;
		end
		if (pause_pulse) begin
			st_next.pause_seen = 1'b1;
		end
		if (st_next.seq_cnt == SEQ_LEN) begin
			st_next.seq_cnt = '0;
			st_next.cmd_mode = !st_reg.cmd_mode;
			st_next.resp_v = 1'b1;
			st_next.resp = MSHI_RESP_OK;
			st_next.rst_req = st_reg.cmd_mode && st_reg.band == MSHI_BAND_900;
		end
		st_next.recog_eff = st_next.cmd_mode || st_next.recog;
		st_next.radio_en = !st_next.cmd_mode;
		// ********************************************************
		// transmit control
		// ********************************************************
		unique case (st_reg.tx)
			MSHI_TX_IDLE: if (buf_count != 11'h000 && !st_reg.cmd_mode) begin
				st_next.tx = radio_rx_busy ? MSHI_TX_WAIT : MSHI_TX_SYNC;
			end
			MSHI_TX_WAIT: if (!radio_rx_busy) st_next.tx = MSHI_TX_SYNC;
			MSHI_TX_SYNC: if (radio_sync_done) st_next.tx = MSHI_TX_SEND;
			MSHI_TX_SEND: if (buf_count == 11'h000 && paused) st_next.tx = MSHI_TX_IDLE;
		endcase
		if (ovf_now && st_reg.tx != MSHI_TX_IDLE) begin
			st_next.tx = MSHI_TX_SYNC;
		end
		st_next.tx_on = (st_next.tx == MSHI_TX_SYNC) || (st_next.tx == MSHI_TX_SEND);
		// ********************************************************
		// cts and receive side
		// ********************************************************
		unique case (st_reg.cts_mode)
			MSHI_CTS_CLEAR: st_next.cts = !(radio_rx_busy || near_full ||
				(st_reg.tx == MSHI_TX_SEND && paused));
			MSHI_CTS_DUTY: st_next.cts = (st_reg.band == MSHI_BAND_800) ? duty_ok :
				!near_full;
			default: st_next.cts = !near_full;
		endcase
		st_next.search = !st_reg.cmd_mode &&
			(st_reg.thresh == THRESH_MIN || $signed(rssi_in) > st_reg.thresh);
		if (rssi_msg_done) begin
			st_next.rssi_hold = rssi_in;
			st_next.rssi_tmr = 28'(RSSI_CYC);
		end else if (st_reg.rssi_tmr != 28'h0000000) begin
			st_next.rssi_tmr = st_reg.rssi_tmr - 28'h0000001;
		end else begin
			st_next.rssi_hold = 8'h00;
		end
	end
	// ************************************************************
	// registers
	// ************************************************************
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_reg <= '0;
			st_reg.recog <= RECOG_RST;
			st_reg.recog_eff <= RECOG_RST;
			st_reg.radio_en <= 1'b1;
			st_reg.addr_chr <= ADDR_RST;
			st_reg.pause_len <= PAUSE_RST;
			st_reg.bit_cyc <= BITCYC_RST;
			st_reg.thresh <= THRESH_MIN;
			st_reg.cts <= 1'b1;
		end else begin
			st_reg <= st_next;
		end
	end
	assign prdata = st_reg.prdata;
	assign pready = st_reg.pready;
	assign pslverr = st_reg.pslverr;
	assign cts_out = st_reg.cts;
	assign radio_tx_on = st_reg.tx_on;
	assign radio_tx_en = st_reg.radio_en;
	assign radio_rx_en = st_reg.radio_en;
	assign search_en = st_reg.search;
	assign dev_reset_req = st_reg.rst_req;
	assign resp_valid = st_reg.resp_v;
	assign resp_code = st_reg.resp;
	assign cfg_cmd_start = st_reg.cfg_start;
	assign addr_start = st_reg.addr_hit;
	assign recog_active = st_reg.recog_eff;
	// ************************************************************
	// checks
	// ************************************************************
	property p_enter_ok;
		@(posedge core_clk) disable iff (!rst_n)
		$rose(st_reg.cmd_mode) |-> resp_valid && resp_code == MSHI_RESP_OK;
	endproperty
	a_enter_ok: assert property (p_enter_ok) else $error("no ok on entry");
	property p_cmd_radio_off;
		@(posedge core_clk) disable iff (!rst_n)
		st_reg.cmd_mode |-> !radio_tx_en && !radio_rx_en && recog_active && !radio_tx_valid;
	endproperty
	a_cmd_radio_off: assert property (p_cmd_radio_off) else $error("radio live in cmd");
	property p_exit_restore;
		@(posedge core_clk) disable iff (!rst_n)
		$fell(st_reg.cmd_mode) |-> resp_valid && radio_tx_en && recog_active == st_reg.recog;
	endproperty
	a_exit_restore: assert property (p_exit_restore) else $error("exit not restored");
	property p_exit_reset;
		@(posedge core_clk) disable iff (!rst_n)
		$fell(st_reg.cmd_mode) |-> dev_reset_req == (st_reg.band == MSHI_BAND_900);
	endproperty
	a_exit_reset: assert property (p_exit_reset) else $error("reset request wrong");
	property p_pause_min;
		@(posedge core_clk) disable iff (!rst_n)
		st_reg.pause_len >= PAUSE_MIN;
	endproperty
	a_pause_min: assert property (p_pause_min) else $error("pause length below 3");
	property p_tx_end;
		@(posedge core_clk) disable iff (!rst_n)
		$fell(radio_tx_on) |-> $past(buf_count) == 11'h000 && $past(paused);
	endproperty
	a_tx_end: assert property (p_tx_end) else $error("tx ended early");
	property p_ovf_flush;
		@(posedge core_clk) disable iff (!rst_n)
		ovf_now |=> buf_count == 11'h000 && st_reg.ovf;
	endproperty
	a_ovf_flush: assert property (p_ovf_flush) else $error("overrun not flushed");
	property p_cts_buf;
		@(posedge core_clk) disable iff (!rst_n)
		st_reg.cts_mode == MSHI_CTS_BUF ##1 st_reg.cts_mode == MSHI_CTS_BUF
		|-> cts_out == ($past(buf_count) < NEAR_FULL);
	endproperty
	a_cts_buf: assert property (p_cts_buf) else $error("cts buffer mode wrong");
	property p_rssi_zero;
		@(posedge core_clk) disable iff (!rst_n)
		st_reg.rssi_tmr == 28'h0000000 ##1 !$past(rssi_msg_done) |-> st_reg.rssi_hold == 8'h00;
	endproperty
	a_rssi_zero: assert property (p_rssi_zero) else $error("rssi not cleared");
	c_cmd_enter: cover property (@(posedge core_clk) disable iff (!rst_n) $rose(st_reg.cmd_mode));
	c_tx_end: cover property (@(posedge core_clk) disable iff (!rst_n) $fell(radio_tx_on));
	c_ovf: cover property (@(posedge core_clk) disable iff (!rst_n) ovf_now);
	c_cfg: cover property (@(posedge core_clk) disable iff (!rst_n) cfg_cmd_start);
endmodule // mshi_top

/* File: bench/mshi_host.sv */
// host terminal model: serial line edge plus decoded byte strobe
module mshi_host (
	input wire logic core_clk, // module clock
	output logic host_tx_line, // idles high
	output logic [7:0] host_byte, // decoded byte
	output logic host_byte_valid // byte strobe
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		host_tx_line = 1'b1;
		host_byte = 8'h00;
		host_byte_valid = 1'b0;
	end
	// mode sequences are only sent with the line otherwise quiet
	task automatic send(input logic [7:0] b);
		host_tx_line <= 1'b0;
		repeat (2) @(posedge core_clk);
		host_tx_line <= 1'b1;
		host_byte <= b;
		host_byte_valid <= 1'b1;
		@(posedge core_clk);
		host_byte_valid <= 1'b0;
		host_byte <= ~b;
	endtask
endmodule // mshi_host

/* File: bench/mshi_top_test.sv */
// self-checking bench of the host serial interface top
module mshi_top_test import mshi_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic core_clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic radio_rx_busy = 1'b0, radio_sync_done = 1'b0, rssi_msg_done = 1'b0;
	logic radio_tx_ready = 1'b1, duty_ok = 1'b1;
	logic [7:0] paddr = 8'h00, rssi_in = 8'h00, host_byte;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, host_tx_line, host_byte_valid, cts_out, radio_tx_valid;
	logic radio_tx_on, radio_tx_en, radio_rx_en, search_en, dev_reset_req, resp_valid;
	logic cfg_cmd_start, addr_start, recog_active, err;
	logic [1:0] resp_code;
	int mismatches = 0, cmp_count = 0, n_ok = 0, n_err = 0, n_rst = 0;
	int n_cfg = 0, n_adr = 0, n_tx = 0;
	always #20 core_clk = ~core_clk;
	// short clamp and hold keep the run brief
	mshi_top #(.PAUSE_CYC(200), .RSSI_CYC(500)) mshi_top_i (.core_clk, .rst_n, .psel,
		.penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .host_tx_line,
		.host_byte, .host_byte_valid, .cts_out, .radio_rx_busy, .radio_sync_done,
		.radio_tx_data(), .radio_tx_valid, .radio_tx_ready, .radio_tx_on,
		.radio_tx_en, .radio_rx_en, .search_en, .rssi_in, .rssi_msg_done, .duty_ok,
		.dev_reset_req, .resp_valid, .resp_code, .cfg_cmd_start, .addr_start, .recog_active);
	mshi_host mshi_host_i (.core_clk, .host_tx_line, .host_byte, .host_byte_valid);
	always @(posedge core_clk) begin
		if (resp_valid === 1'b1 && resp_code === MSHI_RESP_OK) n_ok <= n_ok + 1;
		if (resp_valid === 1'b1 && resp_code === MSHI_RESP_ERROR) n_err <= n_err + 1;
		if (dev_reset_req === 1'b1) n_rst <= n_rst + 1;
		if (cfg_cmd_start === 1'b1) n_cfg <= n_cfg + 1;
		if (addr_start === 1'b1) n_adr <= n_adr + 1;
		if (radio_tx_valid === 1'b1) n_tx <= n_tx + 1;
	end
	// ****************
	// shared tasks
	// ****************
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		cmp_count++;
		if (s !== e) begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		for (i = 0; i < 20; i++) begin
			@(posedge core_clk);
			if (pready === 1'b1) break;
		end
		if (i == 20) begin
			mismatches++;
			conclude();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge core_clk);
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk($sformatf("reg %h", a), rd, e);
	endtask
	task automatic drain();
		cyc(4);
		radio_sync_done <= 1'b1;
		@(posedge core_clk);
		radio_sync_done <= 1'b0;
		cyc(260);
	endtask
	task automatic seq(input logic [7:0] c);
		for (int i = 0; i < 3; i++) begin
			cyc(250);
			mshi_host_i.send(c);
		end
		cyc(3);
	endtask
	// ****************
	// scenarios
	// ****************
	task automatic s_reset();
		rdchk(OFS_CTRL, 32'h1);
		rdchk(OFS_BITCYC, 32'ha2c);
		apb(1'b1, OFS_PAUSE, 32'h1);
		rdchk(OFS_PAUSE, 32'h3);
		apb(1'b1, OFS_PAUSE, 32'hff);
		rdchk(OFS_PAUSE, 32'hff);
		apb(1'b1, OFS_PAUSE, 32'h3);
		apb(1'b0, 8'h40, 32'h0);
		chk("pslverr", err, 1'b1);
		apb(1'b1, OFS_RESP, 32'h1);
		cyc(2);
		chk("error resp", n_err, 1);
	endtask
	task automatic s_cmd();
		apb(1'b1, OFS_CTRL, 32'h10);
		cyc(2);
		chk("recog off", recog_active, 1'b0);
		seq(CHR_PLUS);
		chk("enter ok", n_ok, 1);
		chk("forced", {recog_active, radio_tx_en, radio_rx_en}, 3'b100);
		seq(CHR_MINUS);
		chk("exit ok", n_ok, 2);
		chk("hop reset", n_rst, 1);
		chk("restored", {recog_active, radio_tx_en, radio_rx_en}, 3'b011);
	endtask
	task automatic s_cfg();
		apb(1'b1, OFS_CTRL, 32'h4101);
		cyc(250);
		for (int i = 0; i < 4; i++) mshi_host_i.send(i[0] ? PREFIX1 : PREFIX0);
		cyc(3);
		chk("cfg start", n_cfg, 1);
		cyc(250);
		mshi_host_i.send(8'h41);
		mshi_host_i.send(8'h41);
		cyc(3);
		chk("addr start", n_adr, 1);
	endtask
	task automatic s_tx();
		int t0;
		drain();
		t0 = n_tx;
		radio_rx_busy <= 1'b1;
		for (int i = 0; i < 3; i++) mshi_host_i.send(8'h11);
		cyc(4);
		apb(1'b0, OFS_STATUS, 32'h0);
		chk("count", rd[26:16], 11'h3);
		chk("held", {radio_tx_on, cts_out}, 2'b00);
		radio_rx_busy <= 1'b0;
		cyc(5);
		chk("keyed", radio_tx_on, 1'b1);
		drain();
		chk("sent", n_tx - t0, 3);
		chk("ended", {radio_tx_on, cts_out}, 2'b01);
	endtask
	task automatic s_ovf();
		apb(1'b1, OFS_CTRL, 32'h3);
		radio_rx_busy <= 1'b1;
		mshi_host_i.send(8'h00);
		cyc(3);
		chk("cts buf", cts_out, 1'b1);
		for (int i = 1; i < 970; i++) mshi_host_i.send(8'h00);
		cyc(3);
		chk("cts full", cts_out, 1'b0);
		for (int i = 970; i < 1025; i++) mshi_host_i.send(8'h00);
		cyc(3);
		apb(1'b0, OFS_STATUS, 32'h0);
		chk("overflow", rd[3], 1'b1);
		radio_rx_busy <= 1'b0;
		drain();
	endtask
	task automatic s_duty();
		duty_ok <= 1'b0;
		apb(1'b1, OFS_CTRL, 32'hd);
		mshi_host_i.send(8'h22);
		cyc(2);
		apb(1'b0, OFS_STATUS, 32'h0);
		chk("duty shut", {cts_out, rd[26:16]}, 12'h000);
		duty_ok <= 1'b1;
		mshi_host_i.send(8'h22);
		cyc(2);
		apb(1'b0, OFS_STATUS, 32'h0);
		chk("duty open", {cts_out, rd[26:16]}, 12'h801);
		radio_tx_ready <= 1'b0;
		drain();
		chk("stall", {radio_tx_valid, radio_tx_on}, 2'b11);
		radio_tx_ready <= 1'b1;
		cyc(4);
		chk("duty sent", {radio_tx_valid, radio_tx_on}, 2'b00);
	endtask
	task automatic s_rssi();
		apb(1'b1, OFS_THRESH, 32'h9c);
		rssi_in <= 8'ha6;
		cyc(3);
		chk("search", search_en, 1'b1);
		rssi_in <= 8'h92;
		cyc(3);
		chk("no search", search_en, 1'b0);
		apb(1'b1, OFS_THRESH, 32'h8a);
		cyc(2);
		chk("gate off", search_en, 1'b1);
		rssi_in <= 8'ha6;
		rssi_msg_done <= 1'b1;
		@(posedge core_clk);
		rssi_msg_done <= 1'b0;
		rdchk(OFS_RSSI, 32'ha6);
		cyc(520);
		rdchk(OFS_RSSI, 32'h0);
	endtask
	task automatic conclude();
		$display("mismatches %0d comparisons %0d", mismatches, cmp_count);
		if (mismatches == 0 && cmp_count > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		cyc(16);
		rst_n <= 1'b1;
		cyc(2);
		s_reset();
		s_cmd();
		s_cfg();
		s_tx();
		s_ovf();
		s_duty();
		s_rssi();
		conclude();
	end
	initial begin
		cyc(100000);
		mismatches++;
		conclude();
	end
endmodule // mshi_top_test
